// file: core/rpm_core.sv
// Reset entry, programming entry, idle and power-down control, power
// control register and data pointer pair of a small microcontroller.
// Assumes all pins are sampled synchronously to clk; the CPU reports the
// end of each instruction with instr_done.
// Functional notes
// - Reset pin high two machine cycles resets
// - Ten-bit LSB-first pattern after reset enters programming
// - Crystal input divided by two first
// - Idle stops CPU, A/D and PWM
// - Idle keeps timer, serial bus, interrupts running
// - Idle starts after requesting instruction completes
// - Idle keeps CPU, RAM and registers
// - Enabled interrupt ends idle into its handler
// - Hardware reset ends idle like power-on
// - Power-down stops oscillator after requesting instruction
// - Power-down keeps only internal RAM
// - Only hardware reset ends power-down
// - Mode bits live in power control register
// - Ports hold data, except PWM output pin
// - Pointer pair: 16-bit or two bytes
`timescale 1ns/10ps
`default_nettype none
module rpm_core
    import rpm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Device pins
    input wire logic reset_pin,
    input wire logic crystal_input,
    output logic pwm_output_pin,
    // PWM generator level before the pin
    input wire logic pwm_level,
    // CPU side
    input wire logic instr_done,
    input wire logic irq_pending,
    input wire logic power_control_reg_wr,
    input wire logic [7:0] power_control_reg_wdata,
    input wire rpm_ptr_cmd_s ptr_cmd,
    // Status and control outputs
    output logic device_reset,
    output logic prog_state,
    output logic irq_wake,
    output logic int_tick,
    output rpm_mode_s run_ctl,
    output logic [7:0] power_control_reg,
    output logic [15:0] data_pointer_pair
);
    rpm_state_e state_reg, state_next; // Operating state
    logic [4:0] rst_cnt_reg, rst_cnt_next; // Ticks with reset pin high
    logic [9:0] key_reg, key_next;  // Shift register, LSB first in
    logic armed_reg, armed_next;    // Entry pattern may still arrive
    logic [7:0] power_control_reg_reg, power_control_reg_next; // Power control register
    logic [15:0] ptr_reg, ptr_next; // Data pointer pair
    rpm_mode_s mode_reg, mode_next; // Registered run enables
    logic wake_reg;                 // Interrupt wake pulse
    logic pwm_pin_reg;              // Registered PWM pin
    logic xin_rise;                 // Crystal rising edge
    logic div_q;                    // Divide-by-two output

    // Crystal divider feeding every internal timing decision
    rpm_xin_div u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .crystal_input(crystal_input),
        .osc_run(mode_reg.osc_run),
        .xin_rise(xin_rise),
        .div_q(div_q),
        .int_tick(int_tick)
    );

    // Decoded conditions
    wire in_run = (state_reg == RPM_ST_RUN);
    wire in_idle = (state_reg == RPM_ST_IDLE);
    wire in_pd = (state_reg == RPM_ST_PDOWN);
    wire in_reset = (state_reg == RPM_ST_RESET);
    // Reset pin held long enough while the oscillator runs
    wire rst_long = reset_pin & int_tick
        & (rst_cnt_reg == RPM_RST_TICKS - 5'h01);
    // The oscillator is stopped in power-down, so the pin acts directly
    wire hw_reset = rst_long | (in_pd & reset_pin);
    // Pattern bit is sampled on the crystal edge the programmer aligns to
    wire key_shift = armed_reg & xin_rise;
    wire [9:0] key_shifted = {reset_pin, key_reg[9:1]};
    wire key_hit = key_shift & (key_shifted == RPM_KEY_VALUE);
    // Mode bits as the CPU sees them, including a write this cycle
    wire [7:0] power_control_reg_eff = power_control_reg_wr ? power_control_reg_wdata : power_control_reg_reg;
    wire want_pd = instr_done & power_control_reg_eff[RPM_POWER_CONTROL_REG_PD_BIT];
    wire want_idle = instr_done & power_control_reg_eff[RPM_POWER_CONTROL_REG_IDLE_BIT];
    wire wake_int = in_idle & irq_pending & ~hw_reset;

    // Reset pin counter in internal ticks
    always_comb begin
        rst_cnt_next = rst_cnt_reg;
        if (!reset_pin) begin
            rst_cnt_next = 5'h00;
        end else if (int_tick && rst_cnt_reg != RPM_RST_TICKS) begin
            rst_cnt_next = rst_cnt_reg + 5'h01;
        end
    end

    // State transitions; hardware reset wins over everything
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RPM_ST_RESET: begin
                // Leave reset once the pin falls
                if (!reset_pin) begin
                    state_next = RPM_ST_RUN;
                end
            end
            RPM_ST_RUN: begin
                if (key_hit) begin
                    state_next = RPM_ST_PROG;
                end else if (want_pd) begin
                    state_next = RPM_ST_PDOWN;
                end else if (want_idle) begin
                    state_next = RPM_ST_IDLE;
                end
            end
            RPM_ST_IDLE: begin
                // Only an enabled interrupt or a reset ends idle
                if (wake_int) begin
                    state_next = RPM_ST_RUN;
                end
            end
            RPM_ST_PDOWN: begin
                // Interrupts are ignored here
                state_next = RPM_ST_PDOWN;
            end
            RPM_ST_PROG: begin
                state_next = RPM_ST_PROG;
            end
            default: begin
                state_next = RPM_ST_RESET;
            end
        endcase
        if (hw_reset) begin
            state_next = RPM_ST_RESET;
        end
    end

    // Entry pattern window opens at reset and closes at first instruction
    always_comb begin
        armed_next = armed_reg;
        key_next = key_reg;
        if (in_reset) begin
            armed_next = 1'b1;
        end else if (instr_done || key_hit || !in_run) begin
            armed_next = 1'b0;
        end
        if (key_shift) begin
            key_next = key_shifted;
        end
        if (hw_reset) begin
            key_next = 10'h000;
        end
    end

    // Power control register; mode bits drop when their mode ends
    always_comb begin
        power_control_reg_next = power_control_reg_reg;
        if (power_control_reg_wr) begin
            power_control_reg_next = power_control_reg_wdata;
        end
        if (wake_int) begin
            power_control_reg_next[RPM_POWER_CONTROL_REG_IDLE_BIT] = 1'b0;
        end
        if (hw_reset || in_reset) begin
            power_control_reg_next = RPM_POWER_CONTROL_REG_RESET;
        end
    end

    // Data pointer pair, written as one word or as two bytes
    always_comb begin
        ptr_next = ptr_reg;
        if (ptr_cmd.wr_pair) begin
            ptr_next = ptr_cmd.data;
        end else if (ptr_cmd.inc) begin
            ptr_next = ptr_reg + 16'h0001;
        end else begin
            if (ptr_cmd.wr_hi) begin
                ptr_next[15:8] = ptr_cmd.data[7:0];
            end
            if (ptr_cmd.wr_lo) begin
                ptr_next[7:0] = ptr_cmd.data[7:0];
            end
        end
        // CPU is frozen in idle, so registers stay as they are
        if (state_reg != RPM_ST_RUN) begin
            ptr_next = ptr_reg;
        end
        if (hw_reset || in_reset) begin
            ptr_next = RPM_PTR_RESET;
        end
    end

    // Run enables decoded from the next state so they line up with it
    always_comb begin
        mode_next = '0;
        mode_next.ram_keep = 1'b1;
        case (state_next)
            RPM_ST_RUN: begin
                mode_next.cpu_run = 1'b1;
                mode_next.adc_run = 1'b1;
                mode_next.pwm_run = 1'b1;
                mode_next.keep_run = 1'b1;
                mode_next.osc_run = 1'b1;
                mode_next.sfr_keep = 1'b1;
            end
            RPM_ST_IDLE: begin
                // CPU, A/D and PWM sleep, the rest keeps going
                mode_next.keep_run = 1'b1;
                mode_next.osc_run = 1'b1;
                mode_next.sfr_keep = 1'b1;
                mode_next.port_hold = 1'b1;
            end
            RPM_ST_PDOWN: begin
                // Oscillator off; registers are not guaranteed
                mode_next.port_hold = 1'b1;
            end
            RPM_ST_RESET, RPM_ST_PROG: begin
                mode_next.osc_run = 1'b1;
            end
            default: begin
                mode_next.osc_run = 1'b1;
            end
        endcase
    end

    // State and counters
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= RPM_ST_RESET;
            rst_cnt_reg <= 5'h00;
            armed_reg <= 1'b0;
            key_reg <= 10'h000;
        end else begin
            state_reg <= state_next;
            rst_cnt_reg <= rst_cnt_next;
            armed_reg <= armed_next;
            key_reg <= key_next;
        end
    end

    // Registers seen by the CPU and the chip
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            power_control_reg_reg <= RPM_POWER_CONTROL_REG_RESET;
            ptr_reg <= RPM_PTR_RESET;
            mode_reg <= '0;
            wake_reg <= 1'b0;
            pwm_pin_reg <= 1'b1;
        end else begin
            power_control_reg_reg <= power_control_reg_next;
            ptr_reg <= ptr_next;
            mode_reg <= mode_next;
            wake_reg <= wake_int;
            // PWM pin idles high instead of holding its level
            pwm_pin_reg <= mode_next.pwm_run ? pwm_level : 1'b1;
        end
    end

    // Outputs
    assign device_reset = in_reset;
    assign prog_state = (state_reg == RPM_ST_PROG);
    assign irq_wake = wake_reg;
    assign run_ctl = mode_reg;
    assign power_control_reg = power_control_reg_reg;
    assign data_pointer_pair = ptr_reg;
    assign pwm_output_pin = pwm_pin_reg;

    // Checks

    sequence s_rst_held;
        reset_pin && rst_long && !in_pd;
    endsequence

    property p_rst_entry;
        @(posedge clk) disable iff (sys_rst)
        s_rst_held |=> device_reset;
    endproperty
    a_rst_entry: assert property (p_rst_entry)
        else $error("reset pin held two machine cycles did not reset");

    property p_rst_early;
        @(posedge clk) disable iff (sys_rst)
        (in_run && $rose(reset_pin)) |=> !device_reset [*8];
    endproperty
    a_rst_early: assert property (p_rst_early)
        else $error("reset taken before two machine cycles");

    property p_prog_entry;
        @(posedge clk) disable iff (sys_rst)
        (key_hit && in_run && !hw_reset) |=> prog_state;
    endproperty
    a_prog_entry: assert property (p_prog_entry)
        else $error("entry pattern did not enter programming state");

    property p_div;
        @(posedge clk) disable iff (sys_rst)
        xin_rise |=> (div_q != $past(div_q));
    endproperty
    a_div: assert property (p_div)
        else $error("divider did not toggle on crystal edge");

    property p_idle_gate;
        @(posedge clk) disable iff (sys_rst)
        in_idle |-> (!run_ctl.cpu_run && !run_ctl.adc_run
            && !run_ctl.pwm_run && run_ctl.keep_run && run_ctl.sfr_keep);
    endproperty
    a_idle_gate: assert property (p_idle_gate)
        else $error("idle run enables wrong");

    property p_idle_start;
        @(posedge clk) disable iff (sys_rst)
        (in_run && $past(in_run) && want_idle && !want_pd
            && !key_hit && !hw_reset) |=> in_idle;
    endproperty
    a_idle_start: assert property (p_idle_start)
        else $error("idle not entered at end of instruction");

    sequence s_idle_wake;
        in_idle && irq_pending && !reset_pin;
    endsequence

    property p_idle_wake;
        @(posedge clk) disable iff (sys_rst)
        (s_idle_wake and !hw_reset) |=> (in_run && irq_wake
            && run_ctl.cpu_run);
    endproperty
    a_idle_wake: assert property (p_idle_wake)
        else $error("interrupt did not end idle");

    property p_pd_osc;
        @(posedge clk) disable iff (sys_rst)
        in_pd |-> (!run_ctl.osc_run && !run_ctl.sfr_keep
            && run_ctl.ram_keep && run_ctl.port_hold);
    endproperty
    a_pd_osc: assert property (p_pd_osc)
        else $error("power-down enables wrong");

    property p_pd_stay;
        @(posedge clk) disable iff (sys_rst)
        (in_pd && !reset_pin) |=> in_pd;
    endproperty
    a_pd_stay: assert property (p_pd_stay)
        else $error("power-down left without reset");

    property p_pwm_pin;
        @(posedge clk) disable iff (sys_rst)
        (in_idle || in_pd) |-> pwm_output_pin;
    endproperty
    a_pwm_pin: assert property (p_pwm_pin)
        else $error("PWM pin kept its level in low power");

    property p_ptr_inc;
        @(posedge clk) disable iff (sys_rst)
        (in_run && ptr_cmd.inc && !ptr_cmd.wr_pair && !hw_reset)
            |=> (data_pointer_pair == $past(data_pointer_pair) + 16'h0001);
    endproperty
    a_ptr_inc: assert property (p_ptr_inc)
        else $error("pointer pair did not increment");

endmodule
`default_nettype wire

// file: core/rpm_pkg.sv
// Shared constants and carrier types for the reset and power mode control.
// Assumes a single 40 MHz system clock; every pin is already synchronous.
package rpm_pkg;

    // System clock period in nanoseconds
    localparam int RPM_CLK_PERIOD_NS = 25;

    // Internal (divided) clock ticks in one machine cycle
    localparam logic [3:0] RPM_MC_TICKS = 4'h6;
    // Machine cycles the reset pin must stay high
    localparam logic [3:0] RPM_RST_MCYCLES = 4'h2;
    // Internal ticks the reset pin must stay high, derived from the above
    localparam logic [4:0] RPM_RST_TICKS =
        5'(RPM_MC_TICKS * RPM_RST_MCYCLES);

    // Length of the serial programming entry pattern
    localparam int RPM_KEY_BITS = 10;
    // Entry pattern; the value is arbitrary
    localparam logic [9:0] RPM_KEY_VALUE = 10'h2a5;

    // Power control register layout and reset value
    localparam int RPM_POWER_CONTROL_REG_IDLE_BIT = 0;
    localparam int RPM_POWER_CONTROL_REG_PD_BIT = 1;
    localparam logic [7:0] RPM_POWER_CONTROL_REG_RESET = 8'h00;

    // Data pointer reset value
    localparam logic [15:0] RPM_PTR_RESET = 16'h0000;

    // One-hot operating states
    typedef enum logic [4:0] {
        RPM_ST_RESET = 5'h01,
        RPM_ST_RUN = 5'h02,
        RPM_ST_IDLE = 5'h04,
        RPM_ST_PDOWN = 5'h08,
        RPM_ST_PROG = 5'h10
    } rpm_state_e;

    // Run enables handed to the rest of the chip
    typedef struct packed {
        logic cpu_run;   // CPU executes
        logic adc_run;   // A/D converter clocked
        logic pwm_run;   // PWM clocked
        logic keep_run;  // Timer 0, serial bus, its watchdog, interrupts
        logic osc_run;   // Oscillator running
        logic sfr_keep;  // Special function registers guaranteed kept
        logic ram_keep;  // Internal RAM guaranteed kept
        logic port_hold; // Port pins hold their latched data
    } rpm_mode_s;

    // Data pointer commands from the CPU
    typedef struct packed {
        logic wr_hi;      // Write pointer_high_byte
        logic wr_lo;      // Write pointer_low_byte
        logic wr_pair;    // Write both bytes at once
        logic inc;        // Increment the 16-bit pair
        logic [15:0] data; // Write data, low byte used for single writes
    } rpm_ptr_cmd_s;

endpackage

// file: core/rpm_xin_div.sv
// Crystal input edge detector and divide-by-two stage.
// Assumes crystal_input is already synchronous to clk and much slower.
`timescale 1ns/10ps
`default_nettype none
module rpm_xin_div
    import rpm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Crystal side
    input wire logic crystal_input,
    input wire logic osc_run,
    // Divided clock side
    output logic xin_rise,
    output logic div_q,
    output logic int_tick
);
    logic xin_reg;  // Previous crystal level
    logic div_reg;  // Divide-by-two flip-flop
    logic tick_reg; // One-cycle pulse per divided period

    // Rising edge of the crystal while the oscillator is allowed to run
    assign xin_rise = crystal_input & ~xin_reg & osc_run;
    assign div_q = div_reg;
    assign int_tick = tick_reg;

    // Toggle on every crystal rise so the duty cycle never matters
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            xin_reg <= 1'b0;
            div_reg <= 1'b0;
            tick_reg <= 1'b0;
        end else begin
            xin_reg <= crystal_input;
            div_reg <= div_reg ^ xin_rise;
            tick_reg <= xin_rise & div_reg;
        end
    end

endmodule
`default_nettype wire

// file: tb/rpm_prog_model.sv
// Model of the external reset circuit and serial programmer.
// Assumes its tasks are called at a falling clk edge.
`timescale 1ns/10ps
`default_nettype none
module rpm_prog_model
    import rpm_pkg::*;
(
    // System clock that paces the crystal source
    input wire logic clk,
    // Pins into the device
    output logic reset_pin,
    output logic crystal_input
);
    // Crystal phase; two clk low, two clk high
    logic [1:0] ph_reg = 2'h0;

    // External clock source runs free, as a real oscillator would
    always @(negedge clk) begin
        ph_reg <= ph_reg + 2'h1;
    end
    assign crystal_input = ph_reg[1];

    // Pin starts released so the device can leave reset
    initial reset_pin = 1'b0;

    // Hold the pin high for a given number of crystal rises
    task automatic pulse_pin(input int rises);
        reset_pin <= 1'b1;
        repeat (rises) @(posedge crystal_input);
        @(negedge clk);
        reset_pin <= 1'b0;
    endtask

    // Shift a pattern in, LSB first; each bit changes while the crystal
    // is low so that it is steady at the rise that strobes it
    task automatic send_key(input logic [9:0] key);
        for (int i = 0; i < RPM_KEY_BITS; i++) begin
            @(posedge clk iff ph_reg == 2'h0);
            @(negedge clk);
            reset_pin <= key[i];
        end
        repeat (3) @(negedge clk);
        reset_pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the reset and power mode control.
// Assumes the programmer model drives the reset and crystal pins.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rpm_pkg::*;
    // Expected run_ctl per state, in struct field order
    localparam logic [7:0] M_RUN = 8'hfe;
    localparam logic [7:0] M_IDLE = 8'h1f;
    localparam logic [7:0] M_PD = 8'h03;
    localparam logic [7:0] M_RST = 8'h0a;
    // Pointer command codes: hi, lo, pair, inc
    localparam logic [3:0] C_HI = 4'h8;
    localparam logic [3:0] C_LO = 4'h4;
    localparam logic [3:0] C_PAIR = 4'h2;
    localparam logic [3:0] C_INC = 4'h1;

    // Stimulus
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pwm_level = 1'b0;
    logic instr_done = 1'b0;
    logic irq_pending = 1'b0;
    logic power_control_reg_wr = 1'b0;
    logic [7:0] power_control_reg_wdata = 8'h00;
    rpm_ptr_cmd_s ptr_cmd = '0;
    // Pins from the partner
    wire logic reset_pin;
    wire logic crystal_input;
    // Observed outputs
    logic pwm_output_pin, device_reset, prog_state, irq_wake, int_tick;
    rpm_mode_s run_ctl;
    logic [7:0] power_control_reg;
    logic [15:0] data_pointer_pair;
    // Score
    int mismatches = 0;
    int checked = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    rpm_prog_model prog (.clk(clk), .reset_pin(reset_pin),
        .crystal_input(crystal_input));

    rpm_core uut (.clk(clk), .sys_rst(sys_rst), .reset_pin(reset_pin),
        .crystal_input(crystal_input), .pwm_output_pin(pwm_output_pin),
        .pwm_level(pwm_level), .instr_done(instr_done),
        .irq_pending(irq_pending), .power_control_reg_wr(power_control_reg_wr),
        .power_control_reg_wdata(power_control_reg_wdata), .ptr_cmd(ptr_cmd),
        .device_reset(device_reset), .prog_state(prog_state),
        .irq_wake(irq_wake), .int_tick(int_tick), .run_ctl(run_ctl),
        .power_control_reg(power_control_reg),
        .data_pointer_pair(data_pointer_pair));

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic summarize;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One CPU cycle of strobes; outputs are settled on return
    task automatic go(input logic pw, input logic [7:0] wd,
        input logic idn, input logic irq);
        power_control_reg_wr = pw;
        power_control_reg_wdata = wd;
        instr_done = idn;
        irq_pending = irq;
        @(negedge clk);
        power_control_reg_wr = 1'b0;
        instr_done = 1'b0;
        irq_pending = 1'b0;
    endtask

    // One pointer command
    task automatic ptr(input logic [3:0] k, input logic [15:0] d);
        ptr_cmd = {k, d};
        @(negedge clk);
        ptr_cmd = '0;
    endtask

    // Bounded wait for the device to run again
    task automatic wait_run;
        int n;
        n = 0;
        while (device_reset !== 1'b0 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (device_reset !== 1'b0) begin
            mismatches++;
            summarize;
        end
        tick(1);
        check(16'(run_ctl), 16'(M_RUN));
    endtask

    // Divider rate, short and long reset pulses
    task automatic s_reset;
        int ticks;
        ticks = 0;
        repeat (64) begin
            @(negedge clk);
            if (int_tick === 1'b1) ticks++;
        end
        check(16'(ticks), 16'h0008);
        prog.pulse_pin(20);
        check(16'(device_reset), 16'h0000);
        ptr(C_PAIR, 16'h1234);
        go(1'b1, 8'h80, 1'b0, 1'b0);
        prog.pulse_pin(30);
        check(16'(device_reset), 16'h0001);
        check(16'(run_ctl), 16'(M_RST));
        check(16'(power_control_reg), 16'h0000);
        check(data_pointer_pair, 16'h0000);
        wait_run();
    endtask

    // Programming entry: armed after reset, refused once disarmed
    task automatic s_key;
        prog.pulse_pin(30);
        prog.send_key(RPM_KEY_VALUE);
        check(16'(prog_state), 16'h0001);
        check(16'(run_ctl), 16'(M_RST));
        prog.pulse_pin(30);
        check(16'(prog_state), 16'h0000);
        wait_run();
        go(1'b0, 8'h00, 1'b1, 1'b0);
        prog.send_key(RPM_KEY_VALUE);
        check(16'(prog_state), 16'h0000);
    endtask

    // Idle entry, retention, interrupt exit and reset exit
    task automatic s_idle;
        go(1'b1, 8'h01, 1'b0, 1'b0);
        check(16'(run_ctl), 16'(M_RUN));
        check(16'(power_control_reg), 16'h0001);
        ptr(C_PAIR, 16'h5a5a);
        go(1'b0, 8'h00, 1'b1, 1'b0);
        check(16'(run_ctl), 16'(M_IDLE));
        check(16'(pwm_output_pin), 16'h0001);
        ptr(C_INC, 16'h0000);
        tick(3);
        check(data_pointer_pair, 16'h5a5a);
        check(16'(run_ctl), 16'(M_IDLE));
        go(1'b0, 8'h00, 1'b0, 1'b1);
        check(16'(irq_wake), 16'h0001);
        check(16'(run_ctl), 16'(M_RUN));
        check(16'(power_control_reg), 16'h0000);
        // Software lets the analog references settle before converting
        tick(8);
        go(1'b1, 8'h01, 1'b1, 1'b0);
        check(16'(run_ctl), 16'(M_IDLE));
        prog.pulse_pin(30);
        check(16'(device_reset), 16'h0001);
        check(16'(power_control_reg), 16'h0000);
        wait_run();
    endtask

    // Power-down wins over idle; only the reset pin ends it
    task automatic s_pdown;
        go(1'b1, 8'h03, 1'b1, 1'b0);
        check(16'(run_ctl), 16'(M_PD));
        check(16'(pwm_output_pin), 16'h0001);
        go(1'b0, 8'h00, 1'b0, 1'b1);
        check(16'(irq_wake), 16'h0000);
        go(1'b0, 8'h00, 1'b1, 1'b1);
        check(16'(run_ctl), 16'(M_PD));
        prog.pulse_pin(0);
        check(16'(device_reset), 16'h0001);
        wait_run();
    endtask

    // Pointer as one word and as two bytes; PWM pin follows in run
    task automatic s_ptr;
        ptr(C_PAIR, 16'h12ff);
        ptr(C_INC, 16'h0000);
        check(data_pointer_pair, 16'h1300);
        ptr(C_HI, 16'h00ab);
        ptr(C_LO, 16'h00cd);
        check(data_pointer_pair, 16'habcd);
        ptr(C_HI | C_LO, 16'h0077);
        check(data_pointer_pair, 16'h7777);
        ptr(C_PAIR, 16'hffff);
        ptr(C_INC, 16'h0000);
        check(data_pointer_pair, 16'h0000);
        check(16'(pwm_output_pin), 16'h0000);
        // Pin follows the generator one cycle later while running
        for (int i = 0; i < 4; i++) begin
            pwm_level = i[0];
            tick(1);
            check(16'(pwm_output_pin), 16'(i[0]));
        end
        pwm_level = 1'b0;
    endtask

    // Synchronous reset in mid-run clears state, registers and enables
    task automatic s_sysrst;
        ptr(C_PAIR, 16'hbeef);
        go(1'b1, 8'h80, 1'b0, 1'b0);
        sys_rst = 1'b1;
        tick(1);
        check(16'(device_reset), 16'h0001);
        check(16'(run_ctl), 16'h0000);
        check(16'(power_control_reg), 16'h0000);
        check(data_pointer_pair, 16'h0000);
        check(16'(pwm_output_pin), 16'h0001);
        sys_rst = 1'b0;
        wait_run();
    endtask

    // Main sequence
    initial begin
        tick(5);
        sys_rst = 1'b0;
        wait_run();
        s_reset();
        s_key();
        s_idle();
        s_pdown();
        s_ptr();
        s_sysrst();
        summarize();
    end
endmodule
`default_nettype wire
